// ### rrec_elastic_fifo.sv
/*
 * Nibble-wide elasticity buffer with valid/ready on both sides and a
 * fill level for the hold-back threshold.
 * Assumes DEPTH is a power of two and both sides share mclk.
 */
`timescale 1ns/100ps
module rrec_elastic_fifo import rrec_pkg::*; #(
	parameter int WIDTH = RREC_NIB_BITS,
	parameter int DEPTH = RREC_FIFO_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic flush,
	// fill side
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	// drain side
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data,
	// occupancy
	output logic [AW:0] level
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_ptr_q;
	logic [AW:0] rd_ptr_q;
	logic do_wr;
	logic do_rd;

	// extra pointer bit tells full from empty
	assign level = wr_ptr_q - rd_ptr_q;
	assign wr_ready = (level != (AW+1)'(DEPTH));
	assign rd_valid = (level != '0);
	assign rd_data = mem_q[rd_ptr_q[AW-1:0]];
	assign do_wr = wr_valid && wr_ready;
	assign do_rd = rd_valid && rd_ready;

	// storage, written only when there is room
	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem_q[wr_ptr_q[AW-1:0]] <= wr_data;
		end
	end

	// pointers; flush drops leftovers between packets
	always_ff @(posedge mclk) begin
		if (!rstn || flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

endmodule // rrec_elastic_fifo

// ### rrec_mac_model.sv
/* mac-side sink: gathers dibits the cycle after each slot tick, notes carrier toggling.
   assumes slot ticks at least two cycles apart */
`timescale 1ns/100ps
module rrec_mac_model import rrec_pkg::*; (
	// clock, reset, clear
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clr,
	// reduced interface from the phy
	input wire logic ref_tick,
	input wire logic [3:0] mac_rxd,
	input wire logic mac_crs_dv,
	// observations
	output logic [15:0] cap_q,
	output logic toggled_q
);
	logic tick_d_q, crs_q, fell_q;

	// frames kept at four nibbles, far inside the shortest tolerance reach
	always_ff @(posedge mclk) begin
		tick_d_q <= ref_tick;
		crs_q <= mac_crs_dv;
		if (!rstn || clr) begin
			cap_q <= 16'h0;
			fell_q <= 1'h0;
			toggled_q <= 1'h0;
		end else begin
			if (tick_d_q) begin
				cap_q <= {mac_rxd[1:0], cap_q[15:2]}; // low dibit arrives first
			end
			if (crs_q && !mac_crs_dv) begin
				fell_q <= 1'h1;
			end
			if (fell_q && !crs_q && mac_crs_dv) begin
				toggled_q <= 1'h1;
			end
		end
	end
endmodule // rrec_mac_model

// ### rrec_monitor.sv
/* port checker for rrec_top.
   assumes one mclk domain and a strap held steady through reset */
`timescale 1ns/100ps
module rrec_monitor import rrec_pkg::*; #(
	parameter int DEPTH = RREC_FIFO_DEPTH
) (
	// clock, reset, strap
	input wire logic mclk,
	input wire logic rstn,
	input wire logic strap_reduced_mode,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// receive side
	input wire logic [3:0] rx_nib,
	input wire logic rx_dv_in,
	input wire logic rx_crs_in,
	input wire logic ref_tick,
	// mac side and interrupt
	input wire logic [3:0] mac_rxd,
	input wire logic mac_rx_dv,
	input wire logic mac_crs_dv,
	input wire logic mac_crs,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [3:0] cfg_q;
	logic [1:0] mask_q;
	logic [1:0] seen_q;
	logic rdc_q;

	// mirror of mode, legacy and tolerance; flags are not writable
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cfg_q <= {strap_reduced_mode, RREC_RST_LEGACY, RREC_RST_TOL};
		end else if (reg_wr && reg_addr == RREC_ADDR_CONFIG) begin
			cfg_q <= {reg_wdata[5:4], reg_wdata[1:0]};
		end
	end

	// mirror of the interrupt mask
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mask_q <= RREC_RST_IRQ_MASK;
		end else if (reg_wr && reg_addr == RREC_ADDR_IRQ_MASK) begin
			mask_q <= reg_wdata[1:0];
		end
	end

	// flags once seen set must stay set, nothing but reset clears them
	always_ff @(posedge mclk) begin
		rdc_q <= rstn && reg_rd && reg_addr == RREC_ADDR_CONFIG;
		if (!rstn) begin
			seen_q <= 2'h0;
		end else if (rdc_q) begin
			seen_q <= seen_q | reg_rdata[3:2];
		end
	end

	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data outside its slot");
	a_cfg_readback: assert property (rdc_q |-> {reg_rdata[15:6], reg_rdata[5:4], reg_rdata[1:0]} == {10'h0, $past(cfg_q)})
		else $error("config read back wrong");
	a_flag_sticky: assert property (rdc_q |-> (reg_rdata[3:2] & seen_q) == seen_q)
		else $error("status flag lost");
	a_std_pass: assert property (($past(rstn, 2) && $past(rstn) && !$past(cfg_q[3])) |->
		mac_rxd == $past(rx_nib) && mac_rx_dv == $past(rx_dv_in) && mac_crs == $past(rx_crs_in) && !mac_crs_dv)
		else $error("standard path not a plain delay");
	a_red_quiet: assert property (($past(rstn) && $past(cfg_q[3])) |-> !mac_rx_dv && !mac_crs && mac_rxd[3:2] == 2'h0)
		else $error("standard outputs active in reduced mode");
	a_rxd_slot: assert property (($past(rstn, 2) && $past(rstn) && $past(cfg_q[3]) && $past(cfg_q[3], 2) && !$past(ref_tick))
		|-> $stable(mac_rxd))
		else $error("dibit changed outside slot");
	a_irq_masked: assert property (($past(rstn) && $past(mask_q) == 2'h0 && mask_q == 2'h0) |-> !irq)
		else $error("irq with all masked");
	a_crsdv_start: assert property ((cfg_q[3] && $past(cfg_q[3]) && $rose(rx_dv_in)) |=> mac_crs_dv)
		else $error("carrier valid late");
endmodule // rrec_monitor

bind rrec_top rrec_monitor #(.DEPTH(DEPTH)) u_mon (.mclk(mclk), .rstn(rstn),
	.strap_reduced_mode(strap_reduced_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_nib(rx_nib), .rx_dv_in(rx_dv_in), .rx_crs_in(rx_crs_in),
	.ref_tick(ref_tick), .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv), .mac_crs_dv(mac_crs_dv), .mac_crs(mac_crs),
	.irq(irq));

// ### rrec_pkg.sv
/*
 * Shared constants for the reduced-interface receive path: register
 * offsets, field positions, reset values and elasticity tolerances.
 * Assumes a 16-bit management register space with 5-bit addresses.
 */
package rrec_pkg;

	// register offsets
	localparam logic [4:0] RREC_ADDR_CONFIG = 5'h17;
	localparam logic [4:0] RREC_ADDR_IRQ_MASK = 5'h1e;
	localparam logic [4:0] RREC_ADDR_IRQ_STATUS = 5'h1f;

	// field positions in the configuration register
	localparam int RREC_BIT_MODE = 5;
	localparam int RREC_BIT_LEGACY = 4;
	localparam int RREC_BIT_OVF = 3;
	localparam int RREC_BIT_UNF = 2;
	localparam int RREC_TOL_LSB = 0;

	// field positions in the interrupt status and mask registers
	localparam int RREC_IRQ_BIT_OVF = 1;
	localparam int RREC_IRQ_BIT_UNF = 0;

	// reset values
	localparam logic RREC_RST_LEGACY = 1'b0;
	localparam logic [1:0] RREC_RST_TOL = 2'h1;
	localparam logic [1:0] RREC_RST_IRQ_MASK = 2'h0;

	// tolerance codes and the bits each one absorbs per packet
	localparam logic [1:0] RREC_TOL_CODE_14 = 2'h0;
	localparam logic [1:0] RREC_TOL_CODE_2 = 2'h1;
	localparam logic [1:0] RREC_TOL_CODE_6 = 2'h2;
	localparam logic [1:0] RREC_TOL_CODE_10 = 2'h3;
	localparam int RREC_TOL_BITS_14 = 14;
	localparam int RREC_TOL_BITS_2 = 2;
	localparam int RREC_TOL_BITS_6 = 6;
	localparam int RREC_TOL_BITS_10 = 10;

	// nibble width in bits and buffer depth in nibbles
	localparam int RREC_NIB_BITS = 4;
	localparam int RREC_FIFO_DEPTH = 8;

endpackage

// ### rrec_sync.sv
/*
 * Two-flip-flop level synchroniser, one per bit.
 * Assumes the input comes from a pin or another clock; no reset so the
 * chain only ever carries what the pin shows.
 */
`timescale 1ns/100ps
module rrec_sync import rrec_pkg::*; #(
	parameter int WIDTH = 1
) (
	// clock
	input wire logic mclk,
	// asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge mclk) begin
		meta_q <= async_in;
		sync_out <= meta_q;
	end

endmodule // rrec_sync

// ### rrec_top.sv
/*
 * Reduced-interface mode selection and receive elasticity control:
 * configuration register, strap capture, elasticity buffer drain with
 * carrier/data-valid shaping, overflow/underflow status and interrupt.
 * Assumes receive nibbles and dibit slot strobes come from logic on mclk,
 * the mode strap comes from a pin, and a simple register port master.
 */
// Notes on behaviour
// - bit 5 picks standard or reduced interface; strap reset.
// - standard mode bypasses the reduced-interface logic entirely.
// - bit 4 low: carrier/valid toggles at packet end.
// - bit 4 high: carrier/valid held until last data.
// - bit 3 reports overflow, read-only, resets low.
// - bit 2 reports underflow, read-only, resets low.
// - elasticity buffer absorbs reference versus recovered clock.
// - bits 1:0 choose 14, 2, 6 or 10 bit tolerance.
// - tolerance field resets to 01, the minimum.
// - bits 15:6 ignore writes and read zero.
`timescale 1ns/100ps
module rrec_top import rrec_pkg::*; #(
	parameter int DEPTH = RREC_FIFO_DEPTH
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// strap pin, sampled while reset is held
	input wire logic strap_reduced_mode,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// recovered receive stream, one nibble per rx_nib_valid
	input wire logic [3:0] rx_nib,
	input wire logic rx_nib_valid,
	input wire logic rx_dv_in,
	input wire logic rx_crs_in,
	// dibit slot strobe from the reference clock timing
	input wire logic ref_tick,
	// toward the mac
	output logic [3:0] mac_rxd,
	output logic mac_rx_dv,
	output logic mac_crs_dv,
	output logic mac_crs,
	// interrupt
	output logic irq
);

	localparam int AW = $clog2(DEPTH);

	typedef enum logic [3:0] {
		RREC_IDLE = 4'h1,
		RREC_FILL = 4'h2,
		RREC_STREAM = 4'h4,
		RREC_DONE = 4'h8
	} rrec_state_type;

	rrec_state_type state_q;
	rrec_state_type state_d;

	// configuration and status
	logic mode_q;
	logic legacy_q;
	logic [1:0] tol_q;
	logic ovf_q;
	logic unf_q;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_status_q;
	logic [15:0] rdata_d;

	// strap path
	logic strap_sync;

	// buffer wiring
	logic fifo_flush;
	logic fifo_wr_valid;
	logic fifo_wr_ready;
	logic fifo_rd_valid;
	logic fifo_rd_ready;
	logic [3:0] fifo_rd_data;
	logic [AW:0] fifo_level;
	logic [AW:0] hold_nibs;

	// drain bookkeeping
	logic phase_q;
	logic [1:0] high_dibit_q;
	logic tail_q;
	logic ovf_event;
	logic unf_event;
	logic cfg_wr;

	// strap pin enters through two flip-flops
	rrec_sync #(
		.WIDTH(1)
	) u_strap_sync (
		.mclk(mclk),
		.async_in(strap_reduced_mode),
		.sync_out(strap_sync)
	);

	// tolerance in bits turned into nibbles held before draining;
	// rounded up so a part nibble of drift still has room
	always_comb begin
		case (tol_q)
			RREC_TOL_CODE_14: hold_nibs = (AW+1)'((RREC_TOL_BITS_14 + 3) / RREC_NIB_BITS);
			RREC_TOL_CODE_2: hold_nibs = (AW+1)'((RREC_TOL_BITS_2 + 3) / RREC_NIB_BITS);
			RREC_TOL_CODE_6: hold_nibs = (AW+1)'((RREC_TOL_BITS_6 + 3) / RREC_NIB_BITS);
			RREC_TOL_CODE_10: hold_nibs = (AW+1)'((RREC_TOL_BITS_10 + 3) / RREC_NIB_BITS);
			default: hold_nibs = (AW+1)'(1);
		endcase
	end

	// writes into the buffer only in reduced mode
	assign fifo_wr_valid = mode_q && rx_nib_valid && rx_dv_in && (state_q != RREC_DONE);
	assign fifo_rd_ready = (state_q == RREC_STREAM) && ref_tick && !phase_q;
	// idle flush lets go as soon as data starts, so a nibble that
	// arrives with the first valid cycle is not thrown away
	assign fifo_flush = (state_q == RREC_IDLE && !rx_dv_in) || !mode_q;
	assign ovf_event = mode_q && rx_nib_valid && rx_dv_in && !fifo_wr_ready;
	// an empty slot counts as underflow only while input still runs
	assign unf_event = fifo_rd_ready && !fifo_rd_valid && !tail_q && rx_dv_in;
	assign cfg_wr = reg_wr && (reg_addr == RREC_ADDR_CONFIG);

	// elasticity buffer between recovered data and reference slots
	// depth must cover the largest hold-back plus the drift it absorbs
	rrec_elastic_fifo #(
		.WIDTH(RREC_NIB_BITS),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.flush(fifo_flush),
		.wr_valid(fifo_wr_valid),
		.wr_ready(fifo_wr_ready),
		.wr_data(rx_nib),
		.rd_valid(fifo_rd_valid),
		.rd_ready(fifo_rd_ready),
		.rd_data(fifo_rd_data),
		.level(fifo_level)
	);

	// packet sequencing on the drain side
	always_comb begin
		state_d = state_q;
		case (state_q)
			RREC_IDLE: begin
				if (mode_q && rx_dv_in) begin
					state_d = RREC_FILL;
				end
			end
			RREC_FILL: begin
				// hold back enough to ride out clock drift
				if (fifo_level >= hold_nibs || !rx_dv_in) begin
					state_d = RREC_STREAM;
				end
			end
			RREC_STREAM: begin
				// packet is over once input ended and buffer ran dry
				if (ref_tick && !phase_q && !fifo_rd_valid && tail_q) begin
					state_d = RREC_DONE;
				end
			end
			RREC_DONE: begin
				if (!rx_dv_in && !rx_crs_in) begin
					state_d = RREC_IDLE;
				end
			end
			default: state_d = RREC_IDLE;
		endcase
	end

	// state register; leaving reduced mode abandons any packet
	always_ff @(posedge mclk) begin
		if (!rstn || !mode_q) begin
			state_q <= RREC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// tail marks that the input side has finished the packet
	always_ff @(posedge mclk) begin
		if (!rstn || state_q == RREC_IDLE) begin
			tail_q <= 1'b0;
		end else if (!rx_dv_in) begin
			tail_q <= 1'b1;
		end
	end

	// dibit phase: low dibit on pop, high dibit one slot later
	always_ff @(posedge mclk) begin
		if (!rstn || state_q != RREC_STREAM) begin
			phase_q <= 1'b0;
			high_dibit_q <= 2'h0;
		end else if (ref_tick) begin
			phase_q <= !phase_q;
			if (!phase_q) begin
				high_dibit_q <= fifo_rd_valid ? fifo_rd_data[3:2] : 2'h0;
			end
		end
	end

	// mac-facing outputs, registered
	// standard mode pays one register stage so both paths share timing
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mac_rxd <= 4'h0;
			mac_rx_dv <= 1'b0;
			mac_crs_dv <= 1'b0;
			mac_crs <= 1'b0;
		end else if (!mode_q) begin
			// straight through, reduced logic has no say
			mac_rxd <= rx_nib;
			mac_rx_dv <= rx_dv_in;
			mac_crs_dv <= 1'b0;
			mac_crs <= rx_crs_in;
		end else begin
			mac_rx_dv <= 1'b0;
			mac_crs <= 1'b0;
			if (state_q == RREC_IDLE || state_q == RREC_DONE) begin
				mac_rxd <= 4'h0;
				// carrier seen before data: raise early, data slots follow
				mac_crs_dv <= (state_q == RREC_IDLE) && rx_crs_in;
			end else if (state_q == RREC_FILL) begin
				mac_rxd <= 4'h0;
				mac_crs_dv <= 1'b1;
			end else if (ref_tick) begin
				if (!phase_q) begin
					mac_rxd <= {2'h0, fifo_rd_valid ? fifo_rd_data[1:0] : 2'h0};
				end else begin
					mac_rxd <= {2'h0, high_dibit_q};
				end
				if (!phase_q && !fifo_rd_valid && tail_q) begin
					mac_crs_dv <= 1'b0;
				end else if (!rx_crs_in && !legacy_q) begin
					// carrier gone: high on first dibit, low on second
					mac_crs_dv <= !phase_q;
				end else begin
					// legacy behaviour holds steady to the last dibit
					mac_crs_dv <= 1'b1;
				end
			end
		end
	end

	// configuration bits; strap decides the mode at reset
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mode_q <= strap_sync;
			legacy_q <= RREC_RST_LEGACY;
			tol_q <= RREC_RST_TOL;
		end else if (cfg_wr) begin
			// upper bits are dropped, status bits are not writable
			mode_q <= reg_wdata[RREC_BIT_MODE];
			legacy_q <= reg_wdata[RREC_BIT_LEGACY];
			tol_q <= reg_wdata[RREC_TOL_LSB +: 2];
		end
	end

	// read-only status, sticky until reset
	// no clear path on purpose: software sees the worst case since reset
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end else begin
			if (ovf_event) begin
				ovf_q <= 1'b1;
			end
			if (unf_event) begin
				unf_q <= 1'b1;
			end
		end
	end

	// interrupt mask
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irq_mask_q <= RREC_RST_IRQ_MASK;
		end else if (reg_wr && reg_addr == RREC_ADDR_IRQ_MASK) begin
			irq_mask_q <= reg_wdata[1:0];
		end
	end

	// interrupt status: write one clears, a fresh event wins
	// so an event that meets a clear in one cycle is never lost
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irq_status_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == RREC_IRQ_BIT_OVF && ovf_event) || (i == RREC_IRQ_BIT_UNF && unf_event)) begin
					irq_status_q[i] <= 1'b1;
				end else if (reg_wr && reg_addr == RREC_ADDR_IRQ_STATUS && reg_wdata[i]) begin
					irq_status_q[i] <= 1'b0;
				end
			end
		end
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_mask_q);
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 16'h0000;
		case (reg_addr)
			RREC_ADDR_CONFIG: begin
				rdata_d[RREC_BIT_MODE] = mode_q;
				rdata_d[RREC_BIT_LEGACY] = legacy_q;
				rdata_d[RREC_BIT_OVF] = ovf_q;
				rdata_d[RREC_BIT_UNF] = unf_q;
				rdata_d[RREC_TOL_LSB +: 2] = tol_q;
			end
			RREC_ADDR_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
			RREC_ADDR_IRQ_STATUS: rdata_d[1:0] = irq_status_q;
			default: rdata_d = 16'h0000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	// zeros outside the slot keep a shared read bus quiet
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule // rrec_top

// ### tb_top.sv
/* self-checking bench for rrec_top.
   drives register port and receive stream on mclk; mac model sinks the output */
`timescale 1ns/100ps
module tb_top import rrec_pkg::*;;
	logic mclk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, nv = 1'h0;
	logic dv = 1'h0, crs = 1'h0, tick = 1'h0, clr = 1'h0, strap = 1'h0;
	logic [4:0] addr = 5'h0;
	logic [15:0] wdata = 16'h0, rdata, cap;
	logic [3:0] nib = 4'h0, rxd;
	logic dv_o, crs_dv, crs_o, irq, tg;
	int errors = 0, total_checks = 0;

	rrec_top u_dut (.mclk(mclk), .rstn(rstn), .strap_reduced_mode(strap), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .rx_nib(nib), .rx_nib_valid(nv), .rx_dv_in(dv),
		.rx_crs_in(crs), .ref_tick(tick), .mac_rxd(rxd), .mac_rx_dv(dv_o), .mac_crs_dv(crs_dv), .mac_crs(crs_o),
		.irq(irq));
	rrec_mac_model u_mac (.mclk(mclk), .rstn(rstn), .clr(clr), .ref_tick(tick), .mac_rxd(rxd),
		.mac_crs_dv(crs_dv), .cap_q(cap), .toggled_q(tg));

	// 25 ns clock
	initial begin
		forever #12.5 mclk = ~mclk;
	end

	task stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask

	// data stand only in the cycle after the strobe
	task rc(input logic [4:0] a, input logic [15:0] e);
		@(posedge mclk);
		addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		chk("reg", rdata, e);
	endtask

	task nb(input logic [3:0] n);
		@(posedge mclk);
		nib <= n;
		nv <= 1'h1;
		@(posedge mclk);
		nv <= 1'h0;
	endtask

	task tk(input int n);
		repeat (n) begin
			@(posedge mclk);
			tick <= 1'h1;
			@(posedge mclk);
			tick <= 1'h0;
		end
	endtask

	// whole packet fills first so every tick has a dibit to send; every other tick pops a nibble
	task pk(input logic lg);
		wr(RREC_ADDR_CONFIG, {10'h0, 1'h1, lg, 4'h1});
		clr <= 1'h1;
		@(posedge mclk);
		clr <= 1'h0;
		dv <= 1'h1;
		crs <= 1'h1;
		nb(4'h5);
		nb(4'ha);
		nb(4'h3);
		nb(4'hc);
		dv <= 1'h0;
		crs <= 1'h0;
		tk(8);
		repeat (4) @(posedge mclk);
		chk("data", cap, 16'hc3a5);
		chk("toggle", {15'h0, tg}, {15'h0, !lg});
		// one slot past the last dibit closes the packet
		tk(1);
		#1;
		chk("close", {15'h0, crs_dv}, 16'h0000);
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		stop_test;
	end

	initial begin
		repeat (5) @(posedge mclk);
		rstn <= 1'h1;
		rc(RREC_ADDR_CONFIG, 16'h0001);
		rc(RREC_ADDR_IRQ_MASK, 16'h0000);
		wr(RREC_ADDR_CONFIG, 16'hffff);
		rc(RREC_ADDR_CONFIG, 16'h0033);
		for (int i = 0; i < 4; i++) begin
			wr(RREC_ADDR_CONFIG, 16'(i));
			rc(RREC_ADDR_CONFIG, 16'(i));
		end
		rc(5'h10, 16'h0000);
		@(posedge mclk);
		dv <= 1'h1;
		crs <= 1'h1;
		nb(4'h7);
		nb(4'h2);
		dv <= 1'h0;
		crs <= 1'h0;
		pk(1'h0);
		pk(1'h1);
		wr(RREC_ADDR_CONFIG, 16'h0021);
		// starve the buffer, then overrun it
		@(posedge mclk);
		dv <= 1'h1;
		crs <= 1'h1;
		nb(4'h6);
		tk(4);
		dv <= 1'h0;
		crs <= 1'h0;
		@(posedge mclk);
		dv <= 1'h1;
		crs <= 1'h1;
		repeat (RREC_FIFO_DEPTH + 2) nb(4'h9);
		dv <= 1'h0;
		crs <= 1'h0;
		rc(RREC_ADDR_CONFIG, 16'h002d);
		rc(RREC_ADDR_IRQ_STATUS, 16'h0003);
		chk("irq", {15'h0, irq}, 16'h0000);
		wr(RREC_ADDR_IRQ_MASK, 16'h0002);
		repeat (3) @(posedge mclk);
		#1;
		chk("irq", {15'h0, irq}, 16'h0001);
		wr(RREC_ADDR_IRQ_STATUS, 16'h0003);
		repeat (3) @(posedge mclk);
		#1;
		chk("irq", {15'h0, irq}, 16'h0000);
		rc(RREC_ADDR_IRQ_STATUS, 16'h0000);
		rc(RREC_ADDR_CONFIG, 16'h002d);
		// widest tolerance holds four nibbles before the first slot pops
		wr(RREC_ADDR_CONFIG, 16'h0000);
		wr(RREC_ADDR_CONFIG, 16'h0020);
		@(posedge mclk);
		dv <= 1'h1;
		crs <= 1'h1;
		repeat (3) nb(4'hf);
		tk(1);
		repeat (2) @(posedge mclk);
		chk("hold", {14'h0, cap[15:14]}, 16'h0000);
		nb(4'hf);
		tk(1);
		repeat (2) @(posedge mclk);
		chk("hold", {14'h0, cap[15:14]}, 16'h0003);
		// reset again with the strap high
		dv <= 1'h0;
		crs <= 1'h0;
		strap <= 1'h1;
		rstn <= 1'h0;
		repeat (5) @(posedge mclk);
		rstn <= 1'h1;
		rc(RREC_ADDR_CONFIG, 16'h0021);
		stop_test;
	end
endmodule // tb_top
